// *** inc/servo_cal_pkg.sv ***
// servo calibration console: shared constants and carrier types
// assumes a 40 MHz system clock and an 8N1 serial link at 2400 baud
package servo_cal_pkg;
  localparam int unsigned ClkHz = 40_000_000;
  localparam int unsigned BaudRate = 2400;
  localparam int unsigned BitCycles = ClkHz / BaudRate;
  localparam int unsigned DataBits = 8;
  localparam int unsigned BootDelayMs = 3000;
  localparam int unsigned WindowMs = 1000;
  localparam int unsigned BeepMs = 100;
  localparam int unsigned BootDelayCycles = (ClkHz / 1000) * BootDelayMs;
  localparam int unsigned WindowCycles = (ClkHz / 1000) * WindowMs;
  localparam int unsigned BeepCycles = (ClkHz / 1000) * BeepMs;
  localparam int unsigned PosWidth = 12;
  localparam logic [11:0] PosElecZero = 12'h0800;
  localparam logic [11:0] PosStep = 12'h0010;
  localparam logic [7:0] KeyMinus = 8'h2D;
  localparam logic [7:0] KeyPlus = 8'h2B;
  localparam logic [7:0] KeyEnter = 8'h0D;
  localparam logic [7:0] KeyOne = 8'h31;
  localparam logic [7:0] KeyTwo = 8'h32;
  localparam logic [7:0] KeyFour = 8'h34;
  localparam logic [7:0] KeyFive = 8'h35;
  localparam logic [7:0] KeySix = 8'h36;
  localparam logic [7:0] KeySeven = 8'h37;
  localparam logic [7:0] KeyEight = 8'h38;
  localparam logic [7:0] KeyNine = 8'h39;

  typedef struct packed {
    logic [11:0] front;
    logic [11:0] lower;
  } servo_pair_t;

  typedef struct packed {
    logic wrEn;
    servo_pair_t zeros;
  } nv_write_t;
endpackage

// *** core/servo_calibration_console.sv ***
// servo calibration console: serial receiver, boot sequencer, key interpreter
// assumes rxPin idles high, and an external non-volatile store that presents
// the saved zeros on nvZeros from reset and accepts one-cycle write strobes
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - link runs 2400 baud, 8 data bits, no parity, one stop, no flow control.
// - about 3 s after power-on beep series, then a 1 s key window opens.
// - key in the window gives one beep, calibration mode, servos stay driven.
// - minus key drives both servos to electrical zero, ignoring stored offsets.
// - key 7 steps front servo left, key 9 steps it right, one increment.
// - key 1 stores front servo position as its calibrated zero.
// - key 8 returns front servo to its stored calibrated zero.
// - lower servo: 4 left, 6 right, 2 stores zero, 5 returns to zero.
// - plus key returns both servos to their stored zeros together.
// - carriage return ends calibration mode.
// - at every power-up servos first go to their stored calibrated zeros.
module servo_calibration_console #(
  parameter int unsigned BootDelay = servo_cal_pkg::BootDelayCycles,
  parameter int unsigned WindowLen = servo_cal_pkg::WindowCycles,
  parameter int unsigned BeepLen = servo_cal_pkg::BeepCycles,
  parameter int unsigned BitLen = servo_cal_pkg::BitCycles
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // serial link from the terminal
  input wire logic rxPin,
  // non-volatile zero store
  input wire servo_cal_pkg::servo_pair_t nvZeros,
  output servo_cal_pkg::nv_write_t nvWrite,
  // servo drive
  output servo_cal_pkg::servo_pair_t servoPos,
  output logic servoEnable,
  // status
  output logic beep,
  output logic calMode,
  output logic normalRun
);
  typedef enum logic [4:0] {
    StBoot = 5'b0_0001,
    StBeeps = 5'b0_0010,
    StWindow = 5'b0_0100,
    StCal = 5'b0_1000,
    StRun = 5'b1_0000
  } state_t;

  localparam int unsigned BeepCount = 3;

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  logic rxMeta_r, rxSync_r;
  logic [15:0] bitCnt_r;
  logic [3:0] bitIdx_r;
  logic rxBusy_r;
  logic [7:0] shift_r;
  logic [7:0] rxByte_r;
  logic rxValid_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end else begin
      rxMeta_r <= rxPin;
      rxSync_r <= rxMeta_r;
    end
  end

  // samples each bit mid-cell; frame accepted only with a high stop bit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxBusy_r <= 1'b0;
      bitCnt_r <= 16'h0000;
      bitIdx_r <= 4'h0;
      shift_r <= 8'h00;
      rxByte_r <= 8'h00;
      rxValid_r <= 1'b0;
    end else begin
      rxValid_r <= 1'b0;
      if (!rxBusy_r) begin
        if (!rxSync_r) begin
          rxBusy_r <= 1'b1;
          bitCnt_r <= 16'(BitLen / 2);
          bitIdx_r <= 4'h0;
        end
      end else if (bitCnt_r != 16'h0000) begin
        bitCnt_r <= bitCnt_r - 16'h0001;
      end else begin
        bitCnt_r <= 16'(BitLen - 1);
        bitIdx_r <= bitIdx_r + 4'h1;
        if (bitIdx_r == 4'h0) begin
          if (rxSync_r) rxBusy_r <= 1'b0;
        end else if (bitIdx_r <= 4'(servo_cal_pkg::DataBits)) begin
          shift_r <= {rxSync_r, shift_r[7:1]};
        end else begin
          rxBusy_r <= 1'b0;
          if (rxSync_r) begin
            rxByte_r <= shift_r;
            rxValid_r <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot sequencer
  state_t state_r;
  logic [31:0] timer_r;
  logic [2:0] beepNum_r;
  logic ackBeep_r;
  logic [31:0] ackCnt_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= StBoot;
      timer_r <= 32'h0000_0000;
      beepNum_r <= 3'h0;
    end else begin
      timer_r <= timer_r + 32'h0000_0001;
      case (state_r)
        StBoot: begin
          if (timer_r >= 32'(BootDelay - 1)) begin
            state_r <= StBeeps;
            timer_r <= 32'h0000_0000;
          end
        end
        StBeeps: begin
          if (timer_r >= 32'(2 * BeepLen - 1)) begin
            timer_r <= 32'h0000_0000;
            beepNum_r <= beepNum_r + 3'h1;
            if (beepNum_r == 3'(BeepCount - 1)) state_r <= StWindow;
          end
        end
        StWindow: begin
          if (rxValid_r) begin
            state_r <= StCal;
          end else if (timer_r >= 32'(WindowLen - 1)) begin
            state_r <= StRun;
          end
        end
        StCal: begin
          if (rxValid_r && rxByte_r == servo_cal_pkg::KeyEnter) state_r <= StRun;
        end
        StRun: state_r <= StRun;
        default: state_r <= StBoot;
      endcase
    end
  end

  // single acknowledge beep on entry to calibration
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ackBeep_r <= 1'b0;
      ackCnt_r <= 32'h0000_0000;
    end else if (state_r == StWindow && rxValid_r) begin
      ackBeep_r <= 1'b1;
      ackCnt_r <= 32'(BeepLen - 1);
    end else if (ackCnt_r != 32'h0000_0000) begin
      ackCnt_r <= ackCnt_r - 32'h0000_0001;
    end else begin
      ackBeep_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) beep <= 1'b0;
    else beep <= ackBeep_r || (state_r == StBeeps && timer_r < 32'(BeepLen));
  end

  assign calMode = (state_r == StCal);
  assign normalRun = (state_r == StRun);

  ////////////////////////////////////////////////////////////////////////////
  // key interpreter and servo positions
  logic loaded_r;
  logic [7:0] key;
  logic keyHit;

  assign keyHit = rxValid_r && state_r == StCal;
  assign key = rxByte_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      servoPos.front <= servo_cal_pkg::PosElecZero;
      servoPos.lower <= servo_cal_pkg::PosElecZero;
      loaded_r <= 1'b0;
      servoEnable <= 1'b0;
    end else if (!loaded_r) begin
      servoPos <= nvZeros;
      loaded_r <= 1'b1;
      servoEnable <= 1'b1;
    end else if (keyHit) begin
      case (key)
        servo_cal_pkg::KeyMinus: begin
          servoPos.front <= servo_cal_pkg::PosElecZero;
          servoPos.lower <= servo_cal_pkg::PosElecZero;
        end
        servo_cal_pkg::KeySeven: servoPos.front <= servoPos.front - servo_cal_pkg::PosStep;
        servo_cal_pkg::KeyNine: servoPos.front <= servoPos.front + servo_cal_pkg::PosStep;
        servo_cal_pkg::KeyEight: servoPos.front <= nvZeros.front;
        servo_cal_pkg::KeyFour: servoPos.lower <= servoPos.lower - servo_cal_pkg::PosStep;
        servo_cal_pkg::KeySix: servoPos.lower <= servoPos.lower + servo_cal_pkg::PosStep;
        servo_cal_pkg::KeyFive: servoPos.lower <= nvZeros.lower;
        servo_cal_pkg::KeyPlus: servoPos <= nvZeros;
        default: servoPos <= servoPos;
      endcase
    end
  end

  // store strobes go to the non-volatile store
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nvWrite <= '0;
    end else begin
      nvWrite.wrEn <= 1'b0;
      if (keyHit && key == servo_cal_pkg::KeyOne) begin
        nvWrite.wrEn <= 1'b1;
        nvWrite.zeros <= '{front: servoPos.front, lower: nvZeros.lower};
      end else if (keyHit && key == servo_cal_pkg::KeyTwo) begin
        nvWrite.wrEn <= 1'b1;
        nvWrite.zeros <= '{front: nvZeros.front, lower: servoPos.lower};
      end
    end
  end
endmodule

// *** dv/servo_cal_chk_sva.sv ***
// checker for the servo calibration console ports
// assumes it is bound to every console instance
`timescale 1ns/1ps
module servo_cal_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // console ports
  input wire logic rxPin,
  input wire servo_cal_pkg::servo_pair_t nvZeros,
  input wire servo_cal_pkg::nv_write_t nvWrite,
  input wire servo_cal_pkg::servo_pair_t servoPos,
  input wire logic servoEnable,
  input wire logic beep,
  input wire logic calMode,
  input wire logic normalRun
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_key_taken;
    $rose(calMode);
  endsequence
  chk_boot_zeros: assert property ($rose(servoEnable) |-> servoPos == $past(nvZeros))
    else $error("start position differs from stored zeros");
  chk_drive_held: assert property (servoEnable |=> servoEnable)
    else $error("servo drive dropped");
  chk_mode_excl: assert property (!(calMode && normalRun))
    else $error("both modes active");
  chk_run_sticky: assert property (normalRun |=> normalRun && !calMode)
    else $error("normal run left");
  chk_wr_pulse: assert property (nvWrite.wrEn |=> !nvWrite.wrEn)
    else $error("store strobe too long");
  chk_wr_cal: assert property (nvWrite.wrEn |-> $past(calMode))
    else $error("store outside calibration");
  chk_key_beep: assert property (s_key_taken |-> ##[0:1] beep)
    else $error("no beep on entry");
  chk_pos_quiet: assert property ($changed(servoPos) && $past(servoEnable) |-> $past(calMode))
    else $error("servo moved outside calibration");
endmodule
bind servo_calibration_console servo_cal_chk u_servo_cal_chk (.sys_clk, .nrst, .rxPin,
  .nvZeros, .nvWrite, .servoPos, .servoEnable, .beep, .calMode, .normalRun);

// *** dv/pc_terminal.sv ***
// terminal model: sends 8N1 key frames, line idles high
// assumes the bench clock and a bit length in cycles
`timescale 1ns/1ps
module pc_terminal #(
  parameter int unsigned BitLen = 16
) (
  input wire logic sys_clk,
  output logic txLine
);
  initial txLine = 1'b1;
  task automatic sendKey(input logic [7:0] k);
    logic [9:0] frame;
    frame = {1'b1, k, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      txLine = frame[i];
      repeat (BitLen - 1) @(negedge sys_clk);
    end
  endtask
endmodule

// *** dv/servo_calibration_console_tb.sv ***
// self-checking bench for the servo calibration console
// assumes short boot, window, beep and bit lengths
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module servo_calibration_console_tb;
  localparam int unsigned Boot = 2000;
  localparam int unsigned Win = 1000;
  localparam int unsigned Beep = 50;
  localparam int unsigned Bit = 16;
  localparam logic [11:0] Stp = servo_cal_pkg::PosStep;
  logic sys_clk = 0;
  logic nrst = 0;
  logic rxPin;
  logic servoEnable, beep, calMode, normalRun;
  logic [7:0] k;
  servo_cal_pkg::servo_pair_t nvZeros, servoPos, expPos, expZ;
  servo_cal_pkg::nv_write_t nvWrite;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 79896;
  int i;
  logic [7:0] keys [11] = '{8'h2D, 8'h37, 8'h39, 8'h31, 8'h34, 8'h36, 8'h32, 8'h38,
    8'h35, 8'h2B, 8'h41};
  servo_calibration_console #(.BootDelay(Boot), .WindowLen(Win), .BeepLen(Beep),
    .BitLen(Bit)) u_servo_calibration_console (.sys_clk, .nrst, .rxPin, .nvZeros,
    .nvWrite, .servoPos, .servoEnable, .beep, .calMode, .normalRun);
  pc_terminal #(.BitLen(Bit)) u_pc_terminal (.sys_clk, .txLine(rxPin));
  initial forever #12.5 sys_clk = ~sys_clk;
  // stands in for the non-volatile store
  always @(negedge sys_clk) if (nvWrite.wrEn === 1'b1) nvZeros = nvWrite.zeros;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  function automatic servo_cal_pkg::servo_pair_t nextPos(input logic [7:0] c,
      input servo_cal_pkg::servo_pair_t p, input servo_cal_pkg::servo_pair_t z);
    nextPos = p;
    case (c)
      8'h2D: nextPos = {2{servo_cal_pkg::PosElecZero}};
      8'h37: nextPos.front = p.front - Stp;
      8'h39: nextPos.front = p.front + Stp;
      8'h38: nextPos.front = z.front;
      8'h34: nextPos.lower = p.lower - Stp;
      8'h36: nextPos.lower = p.lower + Stp;
      8'h35: nextPos.lower = z.lower;
      8'h2B: nextPos = z;
      default: ;
    endcase
  endfunction
  task automatic doReset();
    nrst = 0;
    repeat (6) @(negedge sys_clk);
    nrst = 1;
    repeat (2) @(negedge sys_clk);
    `CHK(servoPos, expZ)
    `CHK(servoEnable, 1'b1)
    expPos = expZ;
  endtask
  task automatic key(input logic [7:0] c);
    u_pc_terminal.sendKey(c);
    repeat (Bit) @(negedge sys_clk);
    if (c == 8'h31) expZ.front = expPos.front;
    if (c == 8'h32) expZ.lower = expPos.lower;
    expPos = nextPos(c, expPos, expZ);
    `CHK(servoPos, expPos)
    `CHK(nvZeros, expZ)
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    nvZeros = 24'($random(seed));
    expZ = nvZeros;
    doReset();
    repeat (Boot + 6 * Beep + 100) @(negedge sys_clk);
    u_pc_terminal.sendKey(8'($random(seed)));
    for (i = 0; i < 300 && calMode !== 1'b1; i++) @(negedge sys_clk);
    `CHK(calMode, 1'b1)
    `CHK(beep, 1'b1)
    `CHK(servoPos, expZ)
    for (i = 0; i < 40; i++) begin
      k = 8'($random(seed));
      if (i < 22) k = keys[i % 11];
      if (k == 8'h0D) k = 8'h00;
      key(k);
    end
    u_pc_terminal.sendKey(8'h0D);
    repeat (Bit) @(negedge sys_clk);
    `CHK(normalRun, 1'b1)
    `CHK(calMode, 1'b0)
    u_pc_terminal.sendKey(8'h2D);
    repeat (Bit) @(negedge sys_clk);
    `CHK(servoPos, expPos)
    doReset();
    for (i = 0; i < 4000 && normalRun !== 1'b1; i++) @(negedge sys_clk);
    `CHK(normalRun, 1'b1)
    `CHK(servoPos, expZ)
    end_of_test();
  end
endmodule
